/* src/wdog_pkg.sv */
// Constants for the watchdog control and extended interrupt register block.
// Assumes an APB master with 32-bit data; registers sit in the low byte of each word.
// Functional notes
// - Top control bit doubles second serial port baud rate in modes 1-3.
// - Power-on flag set at power up; only a software write clears it.
// - Timeout sets watchdog interrupt flag; software, power-on reset or external reset clears it.
// - Watchdog reset sets the reset-cause flag until software clears it.
// - Power-fail reset clears reset-cause; watchdog leaves it alone while reset disabled.
// - Reset enable bit at 1 lets timeout reset the device; 0 never.
// - Writing restart reloads the watchdog counter; hardware clears the restart bit.
// - Timeout requests interrupt if enabled; reset follows 512 clocks later if enabled.
// - External reset loads control register to 0x0x0xx0b, x bits kept.
// - Reset-cause is 1 on watchdog reset, 0 on power-on/down, kept on external.
// - Power-on reset sets power-on flag and clears reset enable; others keep it.
// - All bits readable; protected bits written only inside timed-access window.
// - Key AAH then 55H opens protected writes for three machine cycles.
// - Enable register bit 4 gates the watchdog interrupt request.
// - Enable register bits 7-5 always read as 1.
// - Priority register bit 4 selects watchdog interrupt priority level.
// - Four bits enable external interrupts 2-5; four bits set their priority.
package wdog_pkg;
   // Register byte addresses
   localparam logic [11:0] WDOG_CONTROL_ADDR = 12'h00d8;
   localparam logic [11:0] IRQ_ENABLE_ADDR   = 12'h00e8;
   localparam logic [11:0] IRQ_PRIORITY_ADDR = 12'h00f8;
   localparam logic [11:0] TIMED_KEY_ADDR    = 12'h00c7;
   // Control register field positions, then the watchdog bit of the enable and priority registers
   localparam int BIT_BAUD_DOUBLE = 7;
   localparam int BIT_POWER_ON    = 6;
   localparam int BIT_IRQ_FLAG    = 3;
   localparam int BIT_RST_CAUSE   = 2;
   localparam int BIT_RST_ENABLE  = 1;
   localparam int BIT_RESTART     = 0;
   localparam int BIT_WDOG_IRQ    = 4;
   // Bits kept through an external reset (0x0x0xx0b pattern), enable reserved ones, reset value
   localparam logic [7:0] EXT_RST_KEEP_MASK = 8'h56;
   localparam logic [7:0] IRQ_EN_RSVD_ONES  = 8'he0;
   localparam logic [7:0] RESET_VALUE       = 8'h00;
   // Timed access keys and window
   localparam logic [7:0] KEY_FIRST  = 8'haa;
   localparam logic [7:0] KEY_SECOND = 8'h55;
   localparam int CLOCKS_PER_MACHINE_CYCLE = 4;
   localparam int WINDOW_MACHINE_CYCLES    = 3;
   localparam logic [3:0] WINDOW_CYCLES = 4'(WINDOW_MACHINE_CYCLES * CLOCKS_PER_MACHINE_CYCLE);
   // Timeout to reset delay and default watchdog interval
   localparam logic [9:0] RESET_DELAY_CYCLES = 10'd512;
   localparam int TIMEOUT_DEFAULT = 131072;
endpackage

/* src/wdog_counter.sv */
// Watchdog interval counter with restart and timeout pulse.
// Assumes one core clock; restart is a one-cycle pulse from the control logic.
module wdog_counter #(
   parameter int TIMEOUT_CYCLES = wdog_pkg::TIMEOUT_DEFAULT
) (
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   input  wire logic restart_in,
   output logic      timeout_out
);
   logic [31:0] count_r;
   wire         at_end = (count_r == 32'(TIMEOUT_CYCLES - 1));

   // Counts free, wraps at the interval; restart reloads the start state
   always_ff @(posedge core_clk_in) begin
      if (rst_in || restart_in || at_end) begin
         count_r <= 32'h0000_0000;
      end else begin
         count_r <= count_r + 32'h0000_0001;
      end
   end

   // Registered one-cycle timeout pulse
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         timeout_out <= 1'b0;
      end else begin
         timeout_out <= at_end && !restart_in;
      end
   end
endmodule

/* src/wdog_control.sv */
// Watchdog control, reset-cause flags and extended interrupt enable/priority registers.
// Assumes an APB master on core_clk_in; reset kind inputs are synchronous strobes
// from the reset controller; rst_in is the power-on reset itself.
module wdog_control #(
   parameter int TIMEOUT_CYCLES = wdog_pkg::TIMEOUT_DEFAULT
) (
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        ext_reset_in,
   input  wire logic        power_fail_reset_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             serial1_baud_double_out,
   output logic             wdog_irq_out,
   output logic             wdog_irq_priority_out,
   output logic             wdog_reset_out,
   output logic      [3:0]  ext_irq_enable_out,
   output logic      [3:0]  ext_irq_priority_out
);
   logic [7:0] control_r;
   logic [4:0] irq_enable_r;
   logic [4:0] irq_priority_r;
   logic       key_armed_r;
   logic [3:0] window_r;
   logic       delay_run_r;
   logic [9:0] delay_r;
   logic       timeout;
   logic       watchdog_reset_evt;

   // Bus decode
   wire access_now   = psel && penable;
   wire wr_now       = access_now && pwrite;
   wire sel_control  = (paddr == wdog_pkg::WDOG_CONTROL_ADDR);
   wire sel_enable   = (paddr == wdog_pkg::IRQ_ENABLE_ADDR);
   wire sel_priority = (paddr == wdog_pkg::IRQ_PRIORITY_ADDR);
   wire sel_key      = (paddr == wdog_pkg::TIMED_KEY_ADDR);
   wire mapped       = sel_control || sel_enable || sel_priority || sel_key;
   wire [7:0] wbyte  = pwdata[7:0];
   wire wr_control   = wr_now && sel_control;
   wire wr_key       = wr_now && sel_key;
   wire window_open  = (window_r != 4'h0);

   // Protected bits only written inside the window, others always
   wire [7:0] prot_mask  = (8'h01 << wdog_pkg::BIT_POWER_ON) | (8'h01 << wdog_pkg::BIT_RST_ENABLE)
                         | (8'h01 << wdog_pkg::BIT_IRQ_FLAG) | (8'h01 << wdog_pkg::BIT_RESTART);
   wire [7:0] wr_mask    = window_open ? 8'hff : ~prot_mask;
   wire [7:0] ctl_written = wr_control ? ((control_r & ~wr_mask) | (wbyte & wr_mask)) : control_r;
   wire restart_pulse    = wr_control && window_open && wbyte[wdog_pkg::BIT_RESTART];

   // Reset and flag events
   wire rst_enable  = control_r[wdog_pkg::BIT_RST_ENABLE];
   wire irq_enable  = irq_enable_r[wdog_pkg::BIT_WDOG_IRQ];
   assign watchdog_reset_evt = delay_run_r && (delay_r == 10'd1) && rst_enable;

   // Control register next value
   logic [7:0] control_nxt;
   always_comb begin
      control_nxt = ctl_written;
      control_nxt[wdog_pkg::BIT_RESTART] = 1'b0;
      if (timeout) begin
         control_nxt[wdog_pkg::BIT_IRQ_FLAG] = 1'b1;
      end
      if (ext_reset_in) begin
         control_nxt = control_r & wdog_pkg::EXT_RST_KEEP_MASK;
      end
      if (power_fail_reset_in) begin
         control_nxt[wdog_pkg::BIT_RST_CAUSE] = 1'b0;
      end
      if (watchdog_reset_evt) begin
         control_nxt[wdog_pkg::BIT_RST_CAUSE] = 1'b1;
      end
   end

   // Power-on reset sets the power-on flag and clears everything else
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         control_r <= 8'h01 << wdog_pkg::BIT_POWER_ON;
      end else begin
         control_r <= control_nxt;
      end
   end

   // Enable and priority registers; ext reset clears them like the core SFRs
   always_ff @(posedge core_clk_in) begin
      if (rst_in || ext_reset_in) begin
         irq_enable_r   <= 5'h00;
         irq_priority_r <= 5'h00;
      end else begin
         if (wr_now && sel_enable) irq_enable_r <= wbyte[4:0];
         if (wr_now && sel_priority) irq_priority_r <= wbyte[4:0];
      end
   end

   // Timed access: AAH arms, 55H next opens a 3 machine cycle window
   always_ff @(posedge core_clk_in) begin
      if (rst_in || ext_reset_in) begin
         key_armed_r <= 1'b0;
         window_r    <= 4'h0;
      end else begin
         if (wr_key) begin
            key_armed_r <= (wbyte == wdog_pkg::KEY_FIRST);
         end else if (wr_now) begin
            key_armed_r <= 1'b0;
         end
         if (wr_key && key_armed_r && wbyte == wdog_pkg::KEY_SECOND) begin
            window_r <= wdog_pkg::WINDOW_CYCLES;
         end else if (window_open) begin
            window_r <= window_r - 4'h1;
         end
      end
   end

   // Delay from timeout to reset; restart or disabling reset cancels it
   always_ff @(posedge core_clk_in) begin
      if (rst_in || ext_reset_in || watchdog_reset_evt) begin
         delay_run_r <= 1'b0;
         delay_r     <= 10'h000;
      end else if (restart_pulse || !rst_enable) begin
         delay_run_r <= 1'b0;
         delay_r     <= 10'h000;
      end else if (timeout && !delay_run_r) begin
         delay_run_r <= 1'b1;
         delay_r     <= wdog_pkg::RESET_DELAY_CYCLES;
      end else if (delay_run_r) begin
         delay_r <= delay_r - 10'h001;
      end
   end

   wdog_counter #(
      .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
   ) u_counter (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in || ext_reset_in || watchdog_reset_evt),
      .restart_in  (restart_pulse),
      .timeout_out (timeout)
   );

   // Read mux; enable register reserved bits read high
   wire [7:0] rd_byte = sel_control  ? control_r :
                        sel_enable   ? (wdog_pkg::IRQ_EN_RSVD_ONES | {3'b000, irq_enable_r}) :
                        sel_priority ? {3'b000, irq_priority_r} : 8'h00;

   // APB answer: zero wait states, error on unmapped address
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         serial1_baud_double_out <= 1'b0;
         wdog_irq_out            <= 1'b0;
         wdog_irq_priority_out   <= 1'b0;
         wdog_reset_out          <= 1'b0;
         ext_irq_enable_out      <= 4'h0;
         ext_irq_priority_out    <= 4'h0;
      end else begin
         serial1_baud_double_out <= control_r[wdog_pkg::BIT_BAUD_DOUBLE];
         wdog_irq_out            <= control_r[wdog_pkg::BIT_IRQ_FLAG] && irq_enable;
         wdog_irq_priority_out   <= irq_priority_r[wdog_pkg::BIT_WDOG_IRQ];
         wdog_reset_out          <= watchdog_reset_evt;
         ext_irq_enable_out      <= irq_enable_r[3:0];
         ext_irq_priority_out    <= irq_priority_r[3:0];
      end
   end
endmodule

/* verif/wdog_control_properties.sv */
// Concurrent checks on the watchdog control block, attached by bind.
// Assumes one core clock and the synchronous power-on reset rst_in.
module wdog_checker (
   input wire logic        core_clk_in,
   input wire logic        rst_in,
   input wire logic        ext_reset_in,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        serial1_baud_double_out,
   input wire logic        wdog_reset_out,
   input wire logic [3:0]  ext_irq_enable_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // Bus phases; a write in the same cycle as an external reset is left out
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence wr_s(a);
      psel && penable && pready && pwrite && paddr == a && !ext_reset_in;
   endsequence
   // Register lands at the access edge, output flop follows one edge later
   property baud_p;
      wr_s(wdog_pkg::WDOG_CONTROL_ADDR) |-> ##2
         serial1_baud_double_out == $past(pwdata[wdog_pkg::BIT_BAUD_DOUBLE], 2);
   endproperty
   property enable_p;
      wr_s(wdog_pkg::IRQ_ENABLE_ADDR) |-> ##2 ext_irq_enable_out == $past(pwdata[3:0], 2);
   endproperty
   chk_zero_wait: assert property (setup_s |=> pready)
      else $error("access not answered at once");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error without ready or zero data");
   chk_rsvd_ones: assert property (setup_s ##0 (!pwrite && paddr == wdog_pkg::IRQ_ENABLE_ADDR)
      |=> prdata[7:5] == 3'h7)
      else $error("reserved enable bits not high");
   chk_baud_write: assert property (baud_p)
      else $error("baud double bit not written");
   chk_enable_write: assert property (enable_p)
      else $error("external enables not written");
   chk_reset_gap: assert property (wdog_reset_out |=> !wdog_reset_out [*8])
      else $error("watchdog reset not a single pulse");
   chk_ext_baud: assert property (ext_reset_in |=> ##[0:1] !serial1_baud_double_out)
      else $error("external reset kept baud bit");
endmodule

bind wdog_control wdog_checker wdog_checker_inst (
   .core_clk_in             (core_clk_in),
   .rst_in                  (rst_in),
   .ext_reset_in            (ext_reset_in),
   .psel                    (psel),
   .penable                 (penable),
   .pwrite                  (pwrite),
   .paddr                   (paddr),
   .pwdata                  (pwdata),
   .prdata                  (prdata),
   .pready                  (pready),
   .pslverr                 (pslverr),
   .serial1_baud_double_out (serial1_baud_double_out),
   .wdog_reset_out          (wdog_reset_out),
   .ext_irq_enable_out      (ext_irq_enable_out)
);

/* verif/tb.sv */
// Self-checking bench for wdog_control: register rows, then keyed writes,
// timeout and reset kinds. Drives the APB and reset strobes itself.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] e;} row_t;
   logic        core_clk_in = 1'b0, rst_in = 1'b1, ext_reset_in = 1'b0, power_fail_reset_in = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        serial1_baud_double_out, wdog_irq_out, wdog_irq_priority_out, wdog_reset_out;
   logic [3:0]  ext_irq_enable_out, ext_irq_priority_out;
   int          failures = 0, total_checks = 0, n;
   // Address, write data, read mask, expected read; bit 3 masked as timeouts set it
   row_t        rows [5] = '{'{12'h0e8, 8'h1f, 8'hff, 8'hff}, '{12'h0e8, 8'h05, 8'hff, 8'he5},
                             '{12'h0f8, 8'h1a, 8'hff, 8'h1a}, '{12'h0d8, 8'h80, 8'hc7, 8'hc0},
                             '{12'h0d8, 8'h00, 8'hc7, 8'h40}};
   // Short interval keeps the timeout tests brief
   wdog_control #(.TIMEOUT_CYCLES(64)) wdog_control_inst (.*);
   always #12.5 core_clk_in = ~core_clk_in;
   task conclude;
      if (failures == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One transfer; a clock edge passes before the next setup
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_in);
      penable <= 1'b1;
      do begin
         @(posedge core_clk_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k == 20) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, pready, 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk_in);
      failures++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge core_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, 12'h0d8, 32'h0000_0000);
      chk(rd, 32'h0000_0040);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, {24'h00_0000, rows[i].d});
         apb(1'b0, rows[i].a, 32'h0000_0000);
         chk(rd & {24'h00_0000, rows[i].m}, {24'h00_0000, rows[i].e});
      end
      chk({wdog_irq_priority_out, ext_irq_priority_out}, 32'h0000_001a);
      chk(ext_irq_enable_out, 32'h0000_0005);
      apb(1'b1, 12'h0a0, 32'h0000_0012);
      chk(err, 32'h0000_0001);
      // Protected bit ignored without the key
      apb(1'b1, 12'h0d8, 32'h0000_0002);
      apb(1'b0, 12'h0d8, 32'h0000_0000);
      chk(rd & 32'h0000_0003, 32'h0000_0000);
      apb(1'b1, 12'h0e8, 32'h0000_0010);
      apb(1'b1, 12'h0c7, 32'h0000_00aa);
      apb(1'b1, 12'h0c7, 32'h0000_0055);
      apb(1'b1, 12'h0d8, 32'h0000_0003);
      apb(1'b0, 12'h0d8, 32'h0000_0000);
      chk(rd & 32'h0000_0043, 32'h0000_0002);
      // Restart reloaded the counter, so the next timeout is a fresh one
      n = 0;
      while (wdog_irq_out !== 1'b1 && n < 300) begin
         @(posedge core_clk_in);
         n++;
      end
      chk(n < 300, 32'h0000_0001);
      n = 0;
      while (wdog_reset_out !== 1'b1 && n < 700) begin
         @(posedge core_clk_in);
         n++;
      end
      chk(n inside {[511:513]}, 32'h0000_0001);
      apb(1'b0, 12'h0d8, 32'h0000_0000);
      chk(rd & 32'h0000_000e, 32'h0000_000e);
      // Bits 7, 4 and 2 set so the external reset shows which bits it keeps
      apb(1'b1, 12'h0d8, 32'h0000_0094);
      ext_reset_in <= 1'b1;
      @(posedge core_clk_in);
      ext_reset_in <= 1'b0;
      apb(1'b0, 12'h0d8, 32'h0000_0000);
      chk(rd & 32'h0000_00f7, 32'h0000_0016);
      power_fail_reset_in <= 1'b1;
      @(posedge core_clk_in);
      power_fail_reset_in <= 1'b0;
      apb(1'b0, 12'h0d8, 32'h0000_0000);
      chk(rd & 32'h0000_0004, 32'h0000_0000);
      rst_in <= 1'b1;
      @(posedge core_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, 12'h0d8, 32'h0000_0000);
      chk(rd & 32'h0000_00c7, 32'h0000_0040);
      conclude();
   end
endmodule
